/* core/orpd_pkg.sv */
// constants for the on-chip ram partition decoder
package orpd_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_OMR_NEW   = 8'h00;
    localparam logic [7:0] OFS_OMR_LEG   = 8'h04;
    localparam logic [7:0] OFS_CTRL      = 8'h08;
    localparam logic [7:0] OFS_SIZES     = 8'h0C;
    localparam logic [7:0] OFS_WAIT      = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;
    // operating mode field positions
    localparam int BIT_MSW2  = 22;
    localparam int BIT_MSW1  = 21;
    localparam int BIT_MSW0  = 7;
    localparam int BIT_ATE   = 15;
    // writable bits of each operating mode register, others read zero
    localparam logic [23:0] OMR_LEG_MASK = 24'h7FFFFF;
    localparam logic [23:0] OMR_NEW_MASK = 24'h7F7FFF;
    localparam logic [23:0] OMR_RESET    = 24'h000000;
    // control register fields
    localparam int CTRL_CE   = 0;
    localparam int CTRL_LEG  = 1;
    localparam int CTRL_SC   = 2;
    // sizes in 1K words
    localparam logic [7:0] CACHE_K      = 8'h01;
    localparam logic [7:0] SHARED_NEW_K = 8'h0C;
    localparam logic [7:0] SHARED_LEG_K = 8'h0A;
    localparam logic [7:0] LEG_DEF_P_K  = 8'h20;
    localparam logic [7:0] LEG_DEF_XY_K = 8'h30;
    typedef logic [7:0] orpd_k_t;
    localparam orpd_k_t NEW_P_K  [8] = '{8'h20, 8'h28, 8'h30, 8'h40, 8'h48, 8'h50, 8'h60, 8'h70};
    localparam orpd_k_t NEW_XY_K [8] = '{8'h50, 8'h4C, 8'h48, 8'h40, 8'h3C, 8'h38, 8'h30, 8'h28};
    localparam orpd_k_t LEG_P_K  [4] = '{8'h60, 8'h50, 8'h40, 8'h30};
    localparam orpd_k_t LEG_XY_K [4] = '{8'h10, 8'h18, 8'h20, 8'h28};
    // wait state thresholds
    localparam logic [4:0] WS_MIN_NEW = 5'h03;
    localparam logic [4:0] WS_MIN_LEG = 5'h02;
    localparam logic [4:0] WS_TWO     = 5'h08;
    // dram allowed up to this core frequency, mhz
    localparam logic [9:0] DRAM_MAX_MHZ = 10'h064;
    // sixteen-bit compat limit of program top, in 1K words
    localparam logic [7:0] SC_P_LIMIT_K = 8'h40;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage

/* core/orpd_top.sv */
// ram partition decoder with axi4-lite register access
//==========================================================================
// Functional notes
// - cache enable reserves lowest 1K program
// - cached range goes to external memory
// - cache off frees range as program
// - new: bits 22,21,7 form switch select
// - nonzero select moves data ram to program
// - new variant eight program/data sizes
// - legacy: bit 7 enables, 22:21 choose
// - legacy default and four alternate sizes
// - shared filter ram 12K or 10K
// - x and y data kept separate
// - trailing waits one or two appended
// - new variant: no dram, strobes idle
// - legacy dram only up to 100 MHz
// - bit 15 trace enable legacy only
// - reserved mode bits read zero
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module orpd_top
    import orpd_pkg::*;
(
    // clock and reset
    input  wire logic        CORE_CLK_I,
    input  wire logic        RST_N_I,
    // axi4-lite slave
    input  wire logic [7:0]  S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    output logic [1:0]       S_AXI_BRESP_O,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    input  wire logic [7:0]  S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    // decoded map to address decode logic
    output logic [7:0]       PROG_K_O,
    output logic [7:0]       XDATA_K_O,
    output logic [7:0]       YDATA_K_O,
    output logic [7:0]       SHARED_K_O,
    output logic             CACHE_EXT_O,
    output logic             SC_REMAP_O,
    output logic [7:0]       SC_P_LIMIT_O,
    // external bus timing, dram and trace enable
    output logic [1:0]       TRAIL_WS_O,
    output logic             DRAM_EN_O,
    output logic             TRACE_EN_O
);
    //======================================================================
    // registers
    logic [23:0] omr_new_r;
    logic [23:0] omr_leg_r;
    logic [2:0]  ctrl_r;
    logic [4:0]  ws_r;
    logic [9:0]  mhz_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        aw_have_r;
    logic        w_have_r;
    logic        do_wr;
    logic [23:0] wmask;

    assign do_wr = aw_have_r && w_have_r && !S_AXI_BVALID_O;
    assign wmask = {{8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

    //======================================================================
    // axi write channel; address and data taken in either order
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aw_have_r       <= 1'b0;
            w_have_r        <= 1'b0;
            aw_addr_r       <= 8'h00;
            w_data_r        <= 32'h0000_0000;
            w_strb_r        <= 4'h0;
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O  <= 1'b0;
            S_AXI_BVALID_O  <= 1'b0;
            S_AXI_BRESP_O   <= RESP_OKAY;
        end else begin
            S_AXI_AWREADY_O <= !aw_have_r && !S_AXI_AWREADY_O && S_AXI_AWVALID_I;
            S_AXI_WREADY_O  <= !w_have_r && !S_AXI_WREADY_O && S_AXI_WVALID_I;
            if (S_AXI_AWREADY_O && S_AXI_AWVALID_I) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WREADY_O && S_AXI_WVALID_I) begin
                w_have_r <= 1'b1;
                w_data_r <= S_AXI_WDATA_I;
                w_strb_r <= S_AXI_WSTRB_I;
            end
            if (do_wr) begin
                aw_have_r      <= 1'b0;
                w_have_r       <= 1'b0;
                S_AXI_BVALID_O <= 1'b1;
                case (aw_addr_r)
                    OFS_OMR_NEW, OFS_OMR_LEG, OFS_CTRL, OFS_WAIT: begin
                        S_AXI_BRESP_O <= RESP_OKAY;
                    end
                    default: begin
                        S_AXI_BRESP_O <= RESP_SLVERR;
                    end
                endcase
            end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end

    //======================================================================
    // register stores; reserved bits never stored so they read zero
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            omr_new_r <= OMR_RESET;
            omr_leg_r <= OMR_RESET;
            ctrl_r    <= 3'h0;
            ws_r      <= 5'h00;
            mhz_r     <= 10'h000;
        end else if (do_wr) begin
            case (aw_addr_r)
                OFS_OMR_NEW: begin
                    omr_new_r <= (omr_new_r & ~wmask)
                               | (w_data_r[23:0] & wmask & OMR_NEW_MASK);
                end
                OFS_OMR_LEG: begin
                    omr_leg_r <= (omr_leg_r & ~wmask)
                               | (w_data_r[23:0] & wmask & OMR_LEG_MASK);
                end
                OFS_CTRL: begin
                    if (w_strb_r[0]) begin
                        ctrl_r <= w_data_r[2:0];
                    end
                end
                OFS_WAIT: begin
                    if (w_strb_r[0]) begin
                        ws_r <= w_data_r[4:0];
                    end
                    if (w_strb_r[1]) begin
                        mhz_r[7:0] <= w_data_r[15:8];
                    end
                    if (w_strb_r[2]) begin
                        mhz_r[9:8] <= w_data_r[17:16];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    //======================================================================
    // map decode
    logic        leg;
    logic        ce;
    logic [2:0]  sel_new;
    logic [1:0]  sel_leg;
    logic        sw_on;
    logic [7:0]  p_k;
    logic [7:0]  xy_k;
    logic [1:0]  trail;

    assign leg     = ctrl_r[CTRL_LEG];
    assign ce      = ctrl_r[CTRL_CE];
    assign sel_new = {omr_new_r[BIT_MSW2], omr_new_r[BIT_MSW1], omr_new_r[BIT_MSW0]};
    assign sel_leg = {omr_leg_r[BIT_MSW2], omr_leg_r[BIT_MSW1]};
    assign sw_on   = leg ? omr_leg_r[BIT_MSW0] : (sel_new != 3'h0);

    always_comb begin
        if (!leg) begin
            p_k  = NEW_P_K[sel_new];
            xy_k = NEW_XY_K[sel_new];
        end else if (sw_on) begin
            p_k  = LEG_P_K[sel_leg];
            xy_k = LEG_XY_K[sel_leg];
        end else begin
            p_k  = LEG_DEF_P_K;
            xy_k = LEG_DEF_XY_K;
        end
        // usable program shrinks only while cache holds the lowest block
        if (ce) begin
            p_k = p_k - CACHE_K;
        end
    end

    // compare against the variant's own minimum for one trailing wait
    always_comb begin
        if (ws_r >= WS_TWO) begin
            trail = 2'h2;
        end else if (ws_r >= (leg ? WS_MIN_LEG : WS_MIN_NEW)) begin
            trail = 2'h1;
        end else begin
            trail = 2'h0;
        end
    end

    // outputs registered, so they follow a change one cycle later
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PROG_K_O     <= 8'h00;
            XDATA_K_O    <= 8'h00;
            YDATA_K_O    <= 8'h00;
            SHARED_K_O   <= 8'h00;
            CACHE_EXT_O  <= 1'b0;
            SC_REMAP_O   <= 1'b0;
            SC_P_LIMIT_O <= 8'h00;
            TRAIL_WS_O   <= 2'h0;
            DRAM_EN_O    <= 1'b0;
            TRACE_EN_O   <= 1'b0;
        end else begin
            PROG_K_O     <= p_k;
            XDATA_K_O    <= xy_k;
            YDATA_K_O    <= xy_k;
            SHARED_K_O   <= leg ? SHARED_LEG_K : SHARED_NEW_K;
            CACHE_EXT_O  <= ce;
            SC_REMAP_O   <= ctrl_r[CTRL_SC];
            SC_P_LIMIT_O <= ctrl_r[CTRL_SC] ? SC_P_LIMIT_K : p_k;
            TRAIL_WS_O   <= trail;
            DRAM_EN_O    <= leg && (mhz_r <= DRAM_MAX_MHZ);
            TRACE_EN_O   <= leg && omr_leg_r[BIT_ATE];
        end
    end

    //======================================================================
    // axi read channel
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_RDATA_O   <= 32'h0000_0000;
            S_AXI_RRESP_O   <= RESP_OKAY;
        end else begin
            S_AXI_ARREADY_O <= !S_AXI_ARREADY_O && !S_AXI_RVALID_O && S_AXI_ARVALID_I;
            if (S_AXI_ARREADY_O && S_AXI_ARVALID_I) begin
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RRESP_O  <= RESP_OKAY;
                case (S_AXI_ARADDR_I)
                    OFS_OMR_NEW: S_AXI_RDATA_O <= {8'h00, omr_new_r};
                    OFS_OMR_LEG: S_AXI_RDATA_O <= {8'h00, omr_leg_r};
                    OFS_CTRL:    S_AXI_RDATA_O <= {29'h0, ctrl_r};
                    OFS_SIZES:   S_AXI_RDATA_O <= {SHARED_K_O, YDATA_K_O, XDATA_K_O, PROG_K_O};
                    OFS_WAIT:    S_AXI_RDATA_O <= {14'h0, mhz_r, 3'h0, ws_r};
                    OFS_STATUS:  S_AXI_RDATA_O <= {26'h0, TRACE_EN_O, DRAM_EN_O,
                                                   TRAIL_WS_O, CACHE_EXT_O, sw_on};
                    default: begin
                        S_AXI_RDATA_O <= 32'h0000_0000;
                        S_AXI_RRESP_O <= RESP_SLVERR;
                    end
                endcase
            end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end

    //======================================================================
    // assertions
    cache_shrink_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        ctrl_r[CTRL_CE] && !leg && $stable(ctrl_r) && $stable(omr_new_r)
        |=> (PROG_K_O == NEW_P_K[$past(sel_new)] - CACHE_K) && (CACHE_EXT_O == 1'b1))
        else $error("cache size not taken from program ram");
    cache_ext_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        ctrl_r[CTRL_CE] |=> CACHE_EXT_O)
        else $error("cache range not sent external");
    cache_free_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !ctrl_r[CTRL_CE] && !leg |=> PROG_K_O == NEW_P_K[$past(sel_new)])
        else $error("program ram not restored with cache off");
    new_default_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !leg && sel_new == 3'h0 && !ce |=> PROG_K_O == 8'h20 && XDATA_K_O == 8'h50)
        else $error("default map wrong");
    new_switch_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !leg && sel_new != 3'h0 |=> XDATA_K_O < 8'h50)
        else $error("switch mode did not move data ram");
    new_sum_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !leg && !ce |=> (PROG_K_O + XDATA_K_O + YDATA_K_O) == 8'hC0)
        else $error("new variant total not 192K");
    leg_map_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        leg && !ce && sw_on |=> (PROG_K_O + XDATA_K_O + YDATA_K_O) == 8'h80)
        else $error("legacy switch map wrong");
    leg_default_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        leg && !ce && !sw_on |=> PROG_K_O == 8'h20 && YDATA_K_O == 8'h30)
        else $error("legacy default map wrong");
    trail_ws_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        ws_r == 5'h02 |=> TRAIL_WS_O == ($past(leg) ? 2'h1 : 2'h0))
        else $error("trailing waits wrong at two");
    no_dram_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !leg |=> !DRAM_EN_O && !TRACE_EN_O)
        else $error("new variant drove dram or trace");
    rsv_zero_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        omr_new_r[23] == 1'b0 && omr_new_r[BIT_ATE] == 1'b0)
        else $error("reserved mode bit set");
    bresp_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("write response dropped");
    wr_cov: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) do_wr);
    rd_cov: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        S_AXI_RVALID_O && S_AXI_RREADY_I);
    max_cov: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !leg && sel_new == 3'h7 && ce);
    leg_cov: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) leg && sw_on);
endmodule

/* tb/orpd_core_model.sv */
// partner model: core address logic that consumes the decoded map
`timescale 1ns/1ps
module orpd_core_model
    import orpd_pkg::*;
(
    // decoded map in
    input  wire logic [7:0] prog_k_i,
    input  wire logic [7:0] x_k_i,
    input  wire logic [7:0] y_k_i,
    input  wire logic       cache_ext_i,
    input  wire logic       leg_i,
    // what the core derives
    output logic [9:0]      total_k_o,
    output logic [4:0]      min_ws_o
);
    //==========================================================================
    // memory seen by the core
    // the cached 1K is still physical ram, only hidden, so add it back
    assign total_k_o = 10'(prog_k_i) + 10'(cache_ext_i) + 10'(x_k_i) + 10'(y_k_i);
    //==========================================================================
    // bus control programming
    // the core never asks for fewer sram waits than the variant needs
    assign min_ws_o = leg_i ? WS_MIN_LEG : WS_MIN_NEW;
endmodule

/* tb/orpd_top_tb.sv */
// self-checking bench for the ram partition decoder
`timescale 1ns/1ps
module orpd_top_tb
    import orpd_pkg::*;
;
    //==========================================================================
    // signals
    logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, leg, sc;
    logic [7:0]  awaddr, araddr, prog_k, x_k, y_k, sh_k, sc_lim;
    logic [31:0] wdata, rdata, rd, rnd, exp;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        cache_ext, sc_remap, dram_en, trace_en;
    logic [1:0]  bresp, rresp, trail_ws, rs;
    logic [9:0]  total_k, mhz;
    logic [4:0]  min_ws, ws;
    logic [23:0] om;
    int          num_errors, cmp_count, cyc;
    logic [4:0]  ws_tab  [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h07, 5'h08, 5'h1F, 5'h00};
    logic [9:0]  mhz_tab [8] = '{10'h064, 10'h065, 10'h032, 10'h113, 10'h096, 10'h063,
                                 10'h064, 10'h000};

    orpd_top dut (
        .CORE_CLK_I(clk), .RST_N_I(rst_n),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
        .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .PROG_K_O(prog_k), .XDATA_K_O(x_k), .YDATA_K_O(y_k), .SHARED_K_O(sh_k),
        .CACHE_EXT_O(cache_ext), .SC_REMAP_O(sc_remap), .SC_P_LIMIT_O(sc_lim),
        .TRAIL_WS_O(trail_ws), .DRAM_EN_O(dram_en), .TRACE_EN_O(trace_en)
    );
    orpd_core_model core (
        .prog_k_i(prog_k), .x_k_i(x_k), .y_k_i(y_k), .cache_ext_i(cache_ext),
        .leg_i(leg), .total_k_o(total_k), .min_ws_o(min_ws)
    );

    initial clk = 1'b0;
    always #20 clk = ~clk;

    //==========================================================================
    // expectations
    // legacy code is {bit22, bit21, bit7}: bit7 enables, 22:21 choose
    function automatic logic [31:0] exp_map(input logic l, input logic [2:0] s, input logic c);
        logic [7:0] p, xy, sh;
        sh = l ? SHARED_LEG_K : SHARED_NEW_K;
        p  = !l ? NEW_P_K[s] : (s[0] ? LEG_P_K[s[2:1]] : LEG_DEF_P_K);
        xy = !l ? NEW_XY_K[s] : (s[0] ? LEG_XY_K[s[2:1]] : LEG_DEF_XY_K);
        return {sh, xy, xy, p - (c ? CACHE_K : 8'h00)};
    endfunction
    function automatic logic [1:0] exp_trail(input logic l, input logic [4:0] w);
        return (w >= WS_TWO) ? 2'h2 : (w >= (l ? WS_MIN_LEG : WS_MIN_NEW)) ? 2'h1 : 2'h0;
    endfunction

    //==========================================================================
    // checks and bus cycles
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        cmp_count++;
        if (got !== want) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // decoded outputs lag the register by a cycle, so let two edges pass
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_wr(a, d, rs);
        chk(32'(rs), 32'(RESP_OKAY));
        repeat (2) @(posedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
        axi_rd(a, rd, rs);
        chk(rd, want);
        chk(32'(rs), 32'(RESP_OKAY));
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    //==========================================================================
    // hang guard, well above the thousand or so cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    //==========================================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, leg, sc} = 7'h00;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        num_errors = 0;
        cmp_count = 0;
        cyc = 0;
        rnd = $urandom(32'h7E88);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk({sh_k, y_k, x_k, prog_k}, exp_map(1'b0, 3'h0, 1'b0));
        // every select code in both variants, cache off and on, random other bits
        for (int l = 0; l < 2; l++) begin
            leg = l[0];
            for (int s = 0; s < 8; s++) begin
                for (int c = 0; c < 2; c++) begin
                    sc = 1'($urandom);
                    om = (24'($urandom) & 24'h9FFF7F) | {1'b0, s[2], s[1], 13'h0, s[0], 7'h0};
                    exp = exp_map(leg, s[2:0], c[0]);
                    wr(OFS_CTRL, {29'h0, sc, leg, c[0]});
                    wr(leg ? OFS_OMR_LEG : OFS_OMR_NEW, {8'h00, om});
                    chk({sh_k, y_k, x_k, prog_k}, exp);
                    chk(32'(cache_ext), 32'(c[0]));
                    chk(32'(total_k), leg ? 32'h80 : 32'hC0);
                    chk({sc_remap, sc_lim}, {sc, sc ? SC_P_LIMIT_K : exp[7:0]});
                    chk(32'(trace_en), 32'(leg & om[BIT_ATE]));
                    rd_chk(OFS_SIZES, exp);
                    rd_chk(leg ? OFS_OMR_LEG : OFS_OMR_NEW,
                           32'(om & (leg ? OMR_LEG_MASK : OMR_NEW_MASK)));
                    axi_rd(OFS_STATUS, rd, rs);
                    chk(32'(rd[1:0]), {30'h0, c[0], leg ? s[0] : (s != 0)});
                end
            end
        end
        // wait states and dram limit; first entry is the core's minimum
        for (int l = 0; l < 2; l++) begin
            leg = l[0];
            wr(OFS_CTRL, {30'h0, leg, 1'b0});
            for (int i = 0; i < 8; i++) begin
                ws = (i == 0) ? min_ws : (i == 7) ? 5'($urandom) : ws_tab[i];
                mhz = (i == 7) ? 10'($urandom_range(300, 1)) : mhz_tab[i];
                mhz = 10'(mhz);
                wr(OFS_WAIT, {14'h0, mhz, 3'h0, ws});
                chk(32'(trail_ws), 32'(exp_trail(leg, ws)));
                chk(32'(dram_en), 32'(leg && mhz <= DRAM_MAX_MHZ));
            end
        end
        // unmapped read and write to a read-only place
        axi_rd(8'h18, rd, rs);
        chk(rd, 32'h0);
        chk(32'(rs), 32'(RESP_SLVERR));
        exp = {sh_k, y_k, x_k, prog_k};
        axi_wr(OFS_SIZES, 32'h0, rs);
        repeat (2) @(posedge clk);
        chk({sh_k, y_k, x_k, prog_k}, exp);
        chk(32'(rs), 32'(RESP_SLVERR));
        complete_run();
    end
endmodule
